// [logic/mlie_defines.vh]
`ifndef MLIE_DEFINES_VH
`define MLIE_DEFINES_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MLIE_A_INSTR    8'h00
`define MLIE_A_ACCUM    8'h04
`define MLIE_A_STATUS   8'h08
`define MLIE_A_BANK     8'h0C
`define MLIE_A_PCLATCH  8'h10
`define MLIE_A_PTR0     8'h14
`define MLIE_A_PTR1     8'h18
`define MLIE_A_PWRCTL   8'h1C
`define MLIE_A_MEMADDR  8'h20
`define MLIE_A_MEMDATA  8'h24
// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define MLIE_Z_BIT      0
`define MLIE_RI_BIT     0
`define MLIE_BANK_W     5
`define MLIE_PCL_W      7
`define MLIE_PTR_W      16
`define MLIE_FADDR_W    7
// ----------------------------------------------------------------
// instruction encodings
// ----------------------------------------------------------------
`define MLIE_OP_IDLE    14'h0000
`define MLIE_OP_RESET   14'h0001
`define MLIE_OP_BANK    9'h001
`define MLIE_OP_IRD_M   11'h002
`define MLIE_OP_IWR_M   11'h003
`define MLIE_OP_IRD_K   7'h7E
`define MLIE_OP_IWR_K   7'h7F
`define MLIE_OP_PCL     7'h63
`define MLIE_OP_ACC     6'h30
`define MLIE_OP_STORE   7'h01
// ----------------------------------------------------------------
// pointer modes and special file addresses
// ----------------------------------------------------------------
`define MLIE_MM_PREINC  2'h0
`define MLIE_MM_PREDEC  2'h1
`define MLIE_MM_POSTINC 2'h2
`define MLIE_MM_POSTDEC 2'h3
`define MLIE_F_IND0     7'h00
`define MLIE_F_IND1     7'h01
// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define MLIE_RST_BYTE   8'h00
`define MLIE_RST_PTR    16'h0000
`define MLIE_RESP_OKAY  2'h0
`define MLIE_RESP_SLV   2'h2
`endif

// [logic/mlie_dmem.v]
`default_nettype none
// ----------------------------------------------------------------
// data memory, one write port, two read ports
// ----------------------------------------------------------------
module mlie_dmem #(
   parameter AW = 12
) (
   input  wire          clk,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [7:0]    wdata,
   input  wire [AW-1:0] raddr_a,
   output wire [7:0]    rdata_a,
   input  wire [AW-1:0] raddr_b,
   output wire [7:0]    rdata_b
);
   reg [7:0] mem [0:(1<<AW)-1];

   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata_a = mem[raddr_a];
   assign rdata_b = mem[raddr_b];
endmodule // mlie_dmem
`default_nettype wire

// [logic/mlie_core.v]
`include "mlie_defines.vh"
`default_nettype none
module mlie_core #(
   parameter MEM_AW = 12
) (
   input  wire        clk,
   input  wire        rstn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg         device_reset_q
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // true for every decoded register offset
   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `MLIE_A_INSTR) || (a == `MLIE_A_ACCUM) || (a == `MLIE_A_STATUS) ||
                  (a == `MLIE_A_BANK) || (a == `MLIE_A_PCLATCH) || (a == `MLIE_A_PTR0) ||
                  (a == `MLIE_A_PTR1) || (a == `MLIE_A_PWRCTL) || (a == `MLIE_A_MEMADDR) ||
                  (a == `MLIE_A_MEMDATA);
      end
   endfunction

   // one step up or down, wrapping modulo 2^16
   function [`MLIE_PTR_W-1:0] ptr_step;
      input [`MLIE_PTR_W-1:0] p;
      input                   dec;
      begin
         ptr_step = dec ? p - 16'h0001 : p + 16'h0001;
      end
   endfunction

   function [15:0] merge16;
      input [15:0] old;
      input [15:0] nw;
      input [1:0]  strb;
      begin
         merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
      end
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg [7:0]              accum_q;
   reg                    zero_q;
   reg [`MLIE_BANK_W-1:0] bank_q;
   reg [`MLIE_PCL_W-1:0]  pclatch_q;
   reg [`MLIE_PTR_W-1:0]  ptr0_q;
   reg [`MLIE_PTR_W-1:0]  ptr1_q;
   reg                    ri_q;
   reg [15:0]             memaddr_q;
   reg                    aw_hold_q;
   reg [7:0]              awaddr_q;
   reg                    w_hold_q;
   reg [31:0]             wdata_q;
   reg [3:0]              wstrb_q;

   wire       wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
   wire       wr_ok   = mapped(awaddr_q);
   // an instruction runs when its register write lands with both low byte strobes set
   wire       exec    = wr_fire && (awaddr_q == `MLIE_A_INSTR) && (wstrb_q[1:0] == 2'h3);
   wire [13:0] iw     = wdata_q[13:0];

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire is_idle  = (iw == `MLIE_OP_IDLE);
   wire is_reset = (iw == `MLIE_OP_RESET);
   wire is_bank  = (iw[13:5] == `MLIE_OP_BANK);
   wire is_ird_m = (iw[13:3] == `MLIE_OP_IRD_M);
   wire is_iwr_m = (iw[13:3] == `MLIE_OP_IWR_M);
   wire is_ird_k = (iw[13:7] == `MLIE_OP_IRD_K);
   wire is_iwr_k = (iw[13:7] == `MLIE_OP_IWR_K);
   wire is_pcl   = (iw[13:7] == `MLIE_OP_PCL);
   wire is_acc   = (iw[13:8] == `MLIE_OP_ACC);
   wire is_store = (iw[13:7] == `MLIE_OP_STORE);
   wire is_mode  = is_ird_m || is_iwr_m;
   wire is_rel   = is_ird_k || is_iwr_k;
   wire is_ind   = is_mode || is_rel;
   wire is_rd    = is_ird_m || is_ird_k;

   // ----------------------------------------------------------------
   // operand fields
   // ----------------------------------------------------------------
   wire [1:0] mm = iw[1:0];
   wire       sel = is_mode ? iw[2] : iw[6];
   wire [`MLIE_FADDR_W-1:0] faddr = iw[`MLIE_FADDR_W-1:0];

   // ----------------------------------------------------------------
   // address generation
   // ----------------------------------------------------------------
   reg  [`MLIE_PTR_W-1:0] ptr_cur;
   reg  [`MLIE_PTR_W-1:0] eff_addr;
   reg  [`MLIE_PTR_W-1:0] ptr_new;
   reg  [15:0]            st_addr;

   always @* begin
      ptr_cur = sel ? ptr1_q : ptr0_q;
      ptr_new = ptr_cur;
      eff_addr = ptr_cur;
      if (is_rel) begin
         eff_addr = ptr_cur + {{10{iw[5]}}, iw[5:0]};
      end else begin
         case (mm)
            `MLIE_MM_PREINC:  eff_addr = ptr_step(ptr_cur, 1'b0);
            `MLIE_MM_PREDEC:  eff_addr = ptr_step(ptr_cur, 1'b1);
            default:          eff_addr = ptr_cur;
         endcase
         ptr_new = ptr_step(ptr_cur, mm[0]);
      end
      if (faddr == `MLIE_F_IND0) begin
         st_addr = ptr0_q;
      end else if (faddr == `MLIE_F_IND1) begin
         st_addr = ptr1_q;
      end else begin
         st_addr = {4'h0, bank_q, faddr};
      end
   end

   // ----------------------------------------------------------------
   // data memory
   // ----------------------------------------------------------------
   wire [7:0]        rd_byte;
   wire [7:0]        win_byte;
   reg               mem_we;
   reg  [MEM_AW-1:0] mem_waddr;
   reg  [7:0]        mem_wdata;

   always @* begin
      mem_we    = 1'b0;
      mem_waddr = memaddr_q[MEM_AW-1:0];
      mem_wdata = wdata_q[7:0];
      if (exec && (is_iwr_m || is_iwr_k)) begin
         mem_we    = 1'b1;
         mem_waddr = eff_addr[MEM_AW-1:0];
         mem_wdata = accum_q;
      end else if (exec && is_store) begin
         mem_we    = 1'b1;
         mem_waddr = st_addr[MEM_AW-1:0];
         mem_wdata = accum_q;
      end else if (wr_fire && (awaddr_q == `MLIE_A_MEMDATA) && wstrb_q[0]) begin
         mem_we    = 1'b1;
      end
   end

   mlie_dmem #(
      .AW (MEM_AW)
   ) u_dmem (
      .clk     (clk),
      .we      (mem_we),
      .waddr   (mem_waddr),
      .wdata   (mem_wdata),
      .raddr_a (eff_addr[MEM_AW-1:0]),
      .rdata_a (rd_byte),
      .raddr_b (memaddr_q[MEM_AW-1:0]),
      .rdata_b (win_byte)
   );

   // ----------------------------------------------------------------
   // core registers
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      device_reset_q <= 1'b0;
      if (!rstn) begin
         accum_q   <= `MLIE_RST_BYTE;
         zero_q    <= 1'b0;
         bank_q    <= {`MLIE_BANK_W{1'b0}};
         pclatch_q <= {`MLIE_PCL_W{1'b0}};
         ptr0_q    <= `MLIE_RST_PTR;
         ptr1_q    <= `MLIE_RST_PTR;
         ri_q      <= 1'b1;
         memaddr_q <= `MLIE_RST_PTR;
      end else if (exec && is_reset) begin
         // bus logic and memory survive a software reset
         accum_q        <= `MLIE_RST_BYTE;
         zero_q         <= 1'b0;
         bank_q         <= {`MLIE_BANK_W{1'b0}};
         pclatch_q      <= {`MLIE_PCL_W{1'b0}};
         ptr0_q         <= `MLIE_RST_PTR;
         ptr1_q         <= `MLIE_RST_PTR;
         ri_q           <= 1'b0;
         memaddr_q      <= `MLIE_RST_PTR;
         device_reset_q <= 1'b1;
      end else if (exec) begin
         if (is_rd) begin
            accum_q <= rd_byte;
            zero_q  <= (rd_byte == `MLIE_RST_BYTE);
         end
         if (is_mode && !sel) begin
            ptr0_q <= ptr_new;
         end
         if (is_mode && sel) begin
            ptr1_q <= ptr_new;
         end
         if (is_bank) begin
            bank_q <= iw[`MLIE_BANK_W-1:0];
         end
         if (is_pcl) begin
            pclatch_q <= iw[`MLIE_PCL_W-1:0];
         end
         if (is_acc) begin
            accum_q <= iw[7:0];
         end
         // idle, store and indirect words leave ri_q unchanged here
         if (is_idle || is_store || is_ind) begin
            ri_q <= ri_q;
         end
      end else if (wr_fire) begin
         // plain register writes, never alongside an instruction
         case (awaddr_q)
            `MLIE_A_ACCUM:   if (wstrb_q[0]) accum_q <= wdata_q[7:0];
            `MLIE_A_STATUS:  if (wstrb_q[0]) zero_q <= wdata_q[`MLIE_Z_BIT];
            `MLIE_A_BANK:    if (wstrb_q[0]) bank_q <= wdata_q[`MLIE_BANK_W-1:0];
            `MLIE_A_PCLATCH: if (wstrb_q[0]) pclatch_q <= wdata_q[`MLIE_PCL_W-1:0];
            `MLIE_A_PTR0:    ptr0_q <= merge16(ptr0_q, wdata_q[15:0], wstrb_q[1:0]);
            `MLIE_A_PTR1:    ptr1_q <= merge16(ptr1_q, wdata_q[15:0], wstrb_q[1:0]);
            `MLIE_A_PWRCTL:  if (wstrb_q[0]) ri_q <= wdata_q[`MLIE_RI_BIT];
            `MLIE_A_MEMADDR: memaddr_q <= merge16(memaddr_q, wdata_q[15:0], wstrb_q[1:0]);
            default:         ri_q <= ri_q;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite write channels
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (!rstn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_hold_q     <= 1'b0;
         w_hold_q      <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `MLIE_RESP_OKAY;
      end else begin
         if (s_axi_awready && s_axi_awvalid) begin
            aw_hold_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!aw_hold_q) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            w_hold_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (!w_hold_q) begin
            s_axi_wready <= 1'b1;
         end
         if (wr_fire) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `MLIE_RESP_OKAY : `MLIE_RESP_SLV;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // register read mux
   // ----------------------------------------------------------------
   reg [31:0] rd_word;

   always @* begin
      case (s_axi_araddr)
         `MLIE_A_ACCUM:   rd_word = {24'h000000, accum_q};
         `MLIE_A_STATUS:  rd_word = {31'h00000000, zero_q};
         `MLIE_A_BANK:    rd_word = {27'h0000000, bank_q};
         `MLIE_A_PCLATCH: rd_word = {25'h0000000, pclatch_q};
         `MLIE_A_PTR0:    rd_word = {16'h0000, ptr0_q};
         `MLIE_A_PTR1:    rd_word = {16'h0000, ptr1_q};
         `MLIE_A_PWRCTL:  rd_word = {31'h00000000, ri_q};
         `MLIE_A_MEMADDR: rd_word = {16'h0000, memaddr_q};
         `MLIE_A_MEMDATA: rd_word = {24'h000000, win_byte};
         default:         rd_word = 32'h00000000;
      endcase
   end

   // ----------------------------------------------------------------
   // axi4-lite read channels
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `MLIE_RESP_OKAY;
      end else if (s_axi_arready && s_axi_arvalid) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= mapped(s_axi_araddr) ? `MLIE_RESP_OKAY : `MLIE_RESP_SLV;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule // mlie_core
`default_nettype wire

// [dv/mlie_core_asserts.sv]
`include "mlie_defines.vh"
`default_nettype none
// ----------------------------------------------------------------
// port checks for the core
// ----------------------------------------------------------------
module mlie_core_asserts (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        device_reset_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] raddr_q;
   logic [7:0] waddr_q;
   always_ff @(posedge clk) begin
      if (s_axi_arvalid && s_axi_arready) raddr_q <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready) waddr_q <= s_axi_awaddr;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence aw_take_s;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence w_take_s;
      s_axi_wvalid && s_axi_wready;
   endsequence
   sequence b_wait_s;
      ##[1:3] s_axi_bvalid;
   endsequence
   wr_answer_a: assert property (aw_take_s ##0 w_take_s |-> b_wait_s)
      else $error("write response late");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   rd_single_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("second read accepted");
   rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
      else $error("upper read bits set");
   rd_resp_a: assert property (s_axi_rvalid |-> s_axi_rresp == ((raddr_q > `MLIE_A_MEMDATA) ?
      `MLIE_RESP_SLV : `MLIE_RESP_OKAY))
      else $error("read response wrong");
   wr_resp_a: assert property (s_axi_bvalid |-> s_axi_bresp == ((waddr_q > `MLIE_A_MEMDATA) ?
      `MLIE_RESP_SLV : `MLIE_RESP_OKAY))
      else $error("write response wrong");
   rst_pulse_a: assert property (device_reset_q |=> !device_reset_q)
      else $error("reset pulse too long");
   rst_quiet_a: assert property (disable iff (1'h0) !rstn |=> !s_axi_bvalid && !s_axi_rvalid &&
      !device_reset_q && !s_axi_awready)
      else $error("outputs active in reset");
endmodule // mlie_core_asserts

bind mlie_core mlie_core_asserts i_mlie_core_asserts (
   .clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .device_reset_q(device_reset_q)
);
`default_nettype wire

// [dv/test_mlie_core.sv]
`include "mlie_defines.vh"
`default_nettype none
module test_mlie_core;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, device_reset_q;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, v;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [15:0] p, np, ea;
   int          fail_count, n_checks, n_pulse, m;
   mlie_core #(.MEM_AW(12)) i_mlie_core (
      .clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .device_reset_q(device_reset_q)
   );
   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   function automatic logic [1:0] exp_resp(input logic [7:0] a);
      return (a > `MLIE_A_MEMDATA) ? `MLIE_RESP_SLV : `MLIE_RESP_OKAY;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
      // late bready so the response must stand
      repeat (2) @(posedge clk);
      s_axi_bready <= 1'h1;
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk({30'h0, s_axi_bresp}, {30'h0, exp_resp(a)});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      @(posedge clk);
      s_axi_rready <= 1'h1;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk({30'h0, s_axi_rresp}, {30'h0, exp_resp(a)});
      chk(s_axi_rdata, e);
   endtask
   task automatic give_verdict();
      if (fail_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------------------------------
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (device_reset_q === 1'h1) n_pulse++;
   initial begin
      repeat (4000) @(posedge clk);
      fail_count++;
      give_verdict();
   end
   initial begin
      {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      repeat (3) @(posedge clk);
      rstn <= 1'h1;
      rd(`MLIE_A_PWRCTL, 32'h1);
      wr(`MLIE_A_STATUS, 32'h1);
      wr(`MLIE_A_INSTR, 32'h30FF);
      wr(`MLIE_A_INSTR, 32'h3111);
      rd(`MLIE_A_ACCUM, 32'hFF);
      wr(`MLIE_A_INSTR, 32'h003F);
      rd(`MLIE_A_BANK, 32'h1F);
      wr(`MLIE_A_INSTR, 32'h31FF);
      rd(`MLIE_A_PCLATCH, 32'h7F);
      wr(`MLIE_A_INSTR, 32'h0000);
      rd(`MLIE_A_STATUS, 32'h1);
      rd(`MLIE_A_BANK, 32'h1F);
      rd(`MLIE_A_ACCUM, 32'hFF);
      s_axi_wstrb <= 4'h1;
      wr(`MLIE_A_INSTR, 32'h3000);
      s_axi_wstrb <= 4'hF;
      rd(`MLIE_A_ACCUM, 32'hFF);
      wr(`MLIE_A_INSTR, 32'h0023);
      wr(`MLIE_A_INSTR, 32'h305A);
      wr(`MLIE_A_INSTR, 32'h00A5);
      wr(`MLIE_A_MEMADDR, 32'h01A5);
      rd(`MLIE_A_MEMDATA, 32'h5A);
      wr(`MLIE_A_PTR0, 32'h0123);
      wr(`MLIE_A_INSTR, 32'h0080);
      wr(`MLIE_A_MEMADDR, 32'h0123);
      rd(`MLIE_A_MEMDATA, 32'h5A);
      for (m = 0; m < 4; m++) begin
         p = m[0] ? 16'h0000 : 16'hFFFF;
         np = m[0] ? p - 16'h1 : p + 16'h1;
         ea = m[1] ? p : np;
         v = 8'(m * 17);
         wr(`MLIE_A_PTR1, {16'h0, p});
         wr(`MLIE_A_ACCUM, {24'h0, v});
         wr(`MLIE_A_STATUS, 32'h1);
         wr(`MLIE_A_INSTR, 32'h1C | 32'(m));
         rd(`MLIE_A_PTR1, {16'h0, np});
         rd(`MLIE_A_STATUS, 32'h1);
         wr(`MLIE_A_MEMADDR, {16'h0, ea});
         rd(`MLIE_A_MEMDATA, {24'h0, v});
         wr(`MLIE_A_PTR0, {16'h0, p});
         wr(`MLIE_A_ACCUM, 32'hA5);
         wr(`MLIE_A_STATUS, {31'h0, v != 8'h00});
         wr(`MLIE_A_INSTR, 32'h10 | 32'(m));
         rd(`MLIE_A_ACCUM, {24'h0, v});
         rd(`MLIE_A_STATUS, {31'h0, v == 8'h00});
         rd(`MLIE_A_PTR0, {16'h0, np});
      end
      wr(`MLIE_A_PTR0, 32'h0100);
      wr(`MLIE_A_ACCUM, 32'h77);
      wr(`MLIE_A_INSTR, 32'h3FA0);
      rd(`MLIE_A_PTR0, 32'h0100);
      wr(`MLIE_A_PTR1, 32'h00C1);
      wr(`MLIE_A_ACCUM, 32'h0);
      wr(`MLIE_A_STATUS, 32'h1);
      wr(`MLIE_A_INSTR, 32'h3F5F);
      rd(`MLIE_A_ACCUM, 32'h77);
      rd(`MLIE_A_STATUS, 32'h0);
      rd(`MLIE_A_PTR1, 32'h00C1);
      wr(8'h40, 32'h1);
      rd(8'h40, 32'h0);
      wr(`MLIE_A_INSTR, 32'h0001);
      rd(`MLIE_A_PWRCTL, 32'h0);
      rd(`MLIE_A_ACCUM, 32'h0);
      rd(`MLIE_A_PTR0, 32'h0);
      rstn <= 1'h0;
      repeat (3) @(posedge clk);
      rstn <= 1'h1;
      rd(`MLIE_A_PWRCTL, 32'h1);
      chk(32'(n_pulse), 32'h1);
      give_verdict();
   end
endmodule // test_mlie_core
`default_nettype wire
